// ---- hw/blp_protect.v ----
// Protection, supervision and open-drain control for a buck controller with linear regulator
`timescale 1ns/1ps
`include "blp_regs.vh"

module blp_protect #(
  parameter MID_DWELL_CYCLES = `BLP_MID_DWELL_CYCLES,
  parameter UV_ARM_CYCLES    = `BLP_UV_ARM_CYCLES,
  parameter UV_DELAY_CYCLES  = `BLP_UV_DELAY_CYCLES
) (
  input  wire sys_clk_i,
  input  wire resetn_i,
  input  wire switcher_enable_pin_i,
  input  wire linear_reg_enable_pin_i,
  input  wire bias_lockout_i,
  input  wire over_temp_i,
  input  wire sw_cycle_i,
  input  wire fb_over_115_i,
  input  wire fb_over_110_i,
  input  wire fb_under_70_i,
  input  wire fb_under_low_window_i,
  input  wire sense_over_4v_i,
  input  wire sense_below_0v3_i,
  input  wire setting_below_1v36_i,
  input  wire voltage_step_i,
  input  wire ctl_above_1v25_i,
  input  wire ctl_above_0v716_i,
  input  wire ctl_above_0v678_i,
  input  wire linear_overcurrent_i,
  output reg  high_drive_en_o,
  output reg  low_drive_en_o,
  output reg  linear_reg_en_o,
  output reg  linear_current_limit_o,
  output reg  switcher_discharge_o,
  output reg  power_ok_output_o,
  output reg  power_ok_output_oe_n_o,
  output wire multifunction_open_drain_o,
  output reg  multifunction_open_drain_oe_n_o,
  output reg  overvoltage_fault_o,
  output reg  undervoltage_fault_o
);

  // ==========================================================================
  // Input synchronisers
  // ==========================================================================
  // Every pin passes two flops, so drive outputs follow a pin three edges later
  // and the open drain one edge after that. Comparators may chatter near their
  // thresholds, so nothing below ever reads the first flop.
  localparam NSYNC = 17;
  wire [NSYNC-1:0] raw_w = {switcher_enable_pin_i, linear_reg_enable_pin_i, bias_lockout_i,
                            over_temp_i, sw_cycle_i, fb_over_115_i, fb_over_110_i,
                            fb_under_70_i, fb_under_low_window_i, sense_over_4v_i,
                            sense_below_0v3_i, setting_below_1v36_i, voltage_step_i,
                            ctl_above_1v25_i, ctl_above_0v716_i, ctl_above_0v678_i,
                            linear_overcurrent_i};
  reg  [NSYNC-1:0] meta_q;
  reg  [NSYNC-1:0] sync_q;
  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi = gi + 1) begin : g_sync
      always @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
          meta_q[gi] <= 1'b0;
          sync_q[gi] <= 1'b0;
        end else begin
          meta_q[gi] <= raw_w[gi];
          sync_q[gi] <= meta_q[gi];
        end
      end
    end
  endgenerate

  wire sw_en_s    = sync_q[16];
  wire lin_en_s   = sync_q[15];
  wire lockout_s  = sync_q[14];
  wire hot_s      = sync_q[13];
  wire cyc_s      = sync_q[12];
  wire ov115_s    = sync_q[11];
  wire ov110_s    = sync_q[10];
  wire uv70_s     = sync_q[9];
  wire uvwin_s    = sync_q[8];
  wire over4v_s   = sync_q[7];
  wire below03_s  = sync_q[6];
  wire low_set_s  = sync_q[5];
  wire step_s     = sync_q[4];
  wire c125_s     = sync_q[3];
  wire c0716_s    = sync_q[2];
  wire c0678_s    = sync_q[1];
  wire lin_oc_s   = sync_q[0];

  // ==========================================================================
  // Switching cycle edge and shutdown conditions
  // ==========================================================================
  // A switching cycle counts on the rising edge of the synchronised marker;
  // the marker must stay high and low for at least one clock each.
  reg  cyc_prev_q;
  wire cyc_tick = cyc_s & ~cyc_prev_q;
  // Non-latching shutdowns shared by both regulators
  wire inhibit  = lockout_s | hot_s;
  wire sw_run   = sw_en_s & ~inhibit;
  // Switcher disable or lockout clears latches; temperature alone does not
  wire fault_clr = ~sw_en_s | lockout_s;

  // Blanking masks the upper comparators only during a step to a low setting
  wire blank    = step_s & low_set_s;
  wire ov_seen  = ov115_s & ~blank;
  wire high_bad = ov110_s & ~blank;

  // ==========================================================================
  // Undervoltage arming and delay counters
  // ==========================================================================
  reg [10:0] arm_cnt_q;
  reg [10:0] arm_cnt_d;
  reg        uv_armed_q;
  reg        uv_armed_d;
  reg [5:0]  uv_cnt_q;
  reg [5:0]  uv_cnt_d;
  reg        ov_lat_q;
  reg        ov_lat_d;
  reg        uv_lat_q;
  reg        uv_lat_d;
  reg        dis_q;
  reg        dis_d;

  // Arming restarts whenever the switcher is not running, so a restart after
  // lockout or over-temperature gets the full startup grace again
  always @* begin
    arm_cnt_d  = arm_cnt_q;
    uv_armed_d = uv_armed_q;
    if (!sw_run) begin
      arm_cnt_d  = 11'h000;
      uv_armed_d = 1'b0;
    end else if (cyc_tick && !uv_armed_q) begin
      // The counter stops once armed, so it never wraps during long runs
      if (arm_cnt_q == UV_ARM_CYCLES[10:0] - 11'h001)
        uv_armed_d = 1'b1;
      arm_cnt_d = arm_cnt_q + 11'h001;
    end
  end

  // Delay counter runs only while the fault persists; one good sample restarts it
  always @* begin
    uv_cnt_d = uv_cnt_q;
    if (!uv70_s || !uv_armed_q || !sw_run)
      uv_cnt_d = 6'h00;
    else if (cyc_tick && uv_cnt_q != UV_DELAY_CYCLES[5:0])
      uv_cnt_d = uv_cnt_q + 6'h01;
  end

  // Set is tested first, but it needs sw_run, so a fault in a clearing cycle is not latched
  always @* begin
    ov_lat_d = ov_lat_q;
    uv_lat_d = uv_lat_q;
    if (sw_run && ov_seen)
      ov_lat_d = 1'b1;
    else if (fault_clr)
      ov_lat_d = 1'b0;
    if (sw_run && uv_cnt_q == UV_DELAY_CYCLES[5:0])
      uv_lat_d = 1'b1;
    else if (fault_clr)
      uv_lat_d = 1'b0;
  end

  // Discharge runs while latched or disabled and stops below 0.3 V; a fresh
  // enable with no latch ends it at once so the switcher can start
  always @* begin
    dis_d = 1'b0;
    if ((ov_lat_q || uv_lat_q || !sw_en_s) && !below03_s)
      dis_d = 1'b1;
  end

  always @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cyc_prev_q <= 1'b0;
      arm_cnt_q  <= 11'h000;
      uv_armed_q <= 1'b0;
      uv_cnt_q   <= 6'h00;
      ov_lat_q   <= 1'b0;
      uv_lat_q   <= 1'b0;
      dis_q      <= 1'b0;
    end else begin
      cyc_prev_q <= cyc_s;
      arm_cnt_q  <= arm_cnt_d;
      uv_armed_q <= uv_armed_d;
      uv_cnt_q   <= uv_cnt_d;
      ov_lat_q   <= ov_lat_d;
      uv_lat_q   <= uv_lat_d;
      dis_q      <= dis_d;
    end
  end

  // ==========================================================================
  // Drive, regulator and power-ok outputs
  // ==========================================================================
  // Temperature inhibits but never clears a latch, so a hot fault that
  // overlaps an overvoltage resumes still latched once it cools.
  wire latched = ov_lat_q | uv_lat_q;

  always @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      high_drive_en_o        <= 1'b0;
      low_drive_en_o         <= 1'b0;
      linear_reg_en_o        <= 1'b0;
      linear_current_limit_o <= 1'b0;
      switcher_discharge_o   <= 1'b0;
      power_ok_output_o      <= 1'b0;
      power_ok_output_oe_n_o <= 1'b0;
      overvoltage_fault_o    <= 1'b0;
      undervoltage_fault_o   <= 1'b0;
    end else begin
      // Drive enables: the switching modulator gates within these
      high_drive_en_o <= sw_run & ~latched & ~over4v_s & ~dis_q;
      // Overvoltage holds the low side on unless inhibited; undervoltage takes both off
      low_drive_en_o  <= (ov_lat_q & ~uv_lat_q & ~inhibit) |
                         (sw_run & ~latched & ~dis_q);
      linear_reg_en_o <= lin_en_s & ~inhibit;
      // Overcurrent only reports the limit; no effect on the enable
      linear_current_limit_o <= lin_oc_s & lin_en_s;
      switcher_discharge_o   <= dis_q;
      overvoltage_fault_o    <= ov_lat_q;
      undervoltage_fault_o   <= uv_lat_q;
      // Good means running, unlatched, not above 110 percent unless blanked and
      // not below the low window; the linear regulator never enters this.
      // Output always low; enable low pulls the pin to ground when not good
      power_ok_output_o      <= 1'b0;
      power_ok_output_oe_n_o <= sw_run & ~latched & ~high_bad & ~uvwin_s;
    end
  end

  // ==========================================================================
  // Multifunction open drain level table
  // ==========================================================================
  // The dwell counter covers the mid band only; it saturates at the limit
  // and restarts on any excursion, so short visits keep the previous state.
  // Its 13 bits hold the full-length default; a longer dwell needs more bits.
  reg [1:0]  band;
  reg [12:0] dwell_q;
  reg        od_on_q;
  wire       dwell_done = (dwell_q == MID_DWELL_CYCLES[12:0]);

  always @* begin
    if (c125_s)
      band = `BLP_BAND_HIGH;
    else if (c0716_s)
      band = `BLP_BAND_MID;
    else if (c0678_s)
      band = `BLP_BAND_HYST;
    else
      band = `BLP_BAND_LOW;
  end

  always @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      dwell_q <= 13'h0000;
      od_on_q <= 1'b1;
      multifunction_open_drain_oe_n_o <= 1'b0;
    end else begin
      if (band != `BLP_BAND_MID || !lin_en_s)
        dwell_q <= 13'h0000;
      else if (!dwell_done)
        dwell_q <= dwell_q + 13'h0001;
      if (lin_en_s) begin
        case (band)
          `BLP_BAND_HIGH: od_on_q <= 1'b0;
          `BLP_BAND_MID:  if (dwell_done) od_on_q <= 1'b0;
          `BLP_BAND_HYST: od_on_q <= od_on_q;
          `BLP_BAND_LOW:  od_on_q <= 1'b1;
          default:        od_on_q <= 1'b1;
        endcase
      end else if (sw_en_s) begin
        od_on_q <= ~c125_s;
      end else begin
        od_on_q <= 1'b1;
      end
      // The pull-up that makes this a linear power-good belongs to the board
      multifunction_open_drain_oe_n_o <= ~od_on_q;
    end
  end

  // Both open-drain pins only ever pull low; their enables carry the level
  assign multifunction_open_drain_o = 1'b0;

endmodule

// ---- hw/blp_regs.vh ----
// Timing counts and comparator band codes for the buck/linear protection logic
`ifndef BLP_REGS_VH
`define BLP_REGS_VH
// Switching cycles a feedback undervoltage must persist before latch-off
`define BLP_UV_DELAY_CYCLES   32
// Switching cycles after switcher start before undervoltage shutdown is armed
`define BLP_UV_ARM_CYCLES     1007
// Mid-band dwell time before the open drain turns off, in ns
`define BLP_MID_DWELL_NS      45000
`define BLP_CLK_PERIOD_NS     8
// Longest time rounds down: 45000 / 8 = 5625 cycles
`define BLP_MID_DWELL_CYCLES  (`BLP_MID_DWELL_NS / `BLP_CLK_PERIOD_NS)
// Band codes of the drain control input comparators
`define BLP_BAND_LOW          2'h0
`define BLP_BAND_HYST         2'h1
`define BLP_BAND_MID          2'h2
`define BLP_BAND_HIGH         2'h3
`endif

// ---- verif/blp_protect_asserts.sv ----
// Port-level concurrent checks for the buck and linear protection logic
`timescale 1ns/1ps
module blp_protect_chk (
  input wire sys_clk_i,
  input wire resetn_i,
  input wire linear_reg_enable_pin_i,
  input wire bias_lockout_i,
  input wire over_temp_i,
  input wire sense_over_4v_i,
  input wire ctl_above_1v25_i,
  input wire ctl_above_0v678_i,
  input wire high_drive_en_o,
  input wire low_drive_en_o,
  input wire linear_reg_en_o,
  input wire multifunction_open_drain_oe_n_o,
  input wire overvoltage_fault_o,
  input wire undervoltage_fault_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);
  // ==========================================================
  // Drive outputs follow a latch on the same edge as its fault flag, which is sampled twice
  ov_high_off_a: assert property (overvoltage_fault_o [*2] |-> !high_drive_en_o)
    else $error("high side on in overvoltage");
  uv_both_off_a: assert property (undervoltage_fault_o [*2] |->
    !high_drive_en_o && !low_drive_en_o)
    else $error("drive on in undervoltage");
  // Inputs pass two sync flops, so five samples cover the latency
  sense_limit_a: assert property (sense_over_4v_i [*5] |-> !high_drive_en_o)
    else $error("high side on above 4 V");
  lockout_off_a: assert property (bias_lockout_i [*5] |->
    !high_drive_en_o && !low_drive_en_o && !linear_reg_en_o)
    else $error("output on in lockout");
  hot_off_a: assert property (over_temp_i [*5] |->
    !high_drive_en_o && !linear_reg_en_o)
    else $error("output on when hot");
  linear_on_a: assert property (
    (linear_reg_enable_pin_i && !bias_lockout_i && !over_temp_i) [*5] |-> linear_reg_en_o)
    else $error("linear off without cause");
  od_high_off_a: assert property (
    (linear_reg_enable_pin_i && ctl_above_1v25_i) [*6] |-> multifunction_open_drain_oe_n_o)
    else $error("drain on above 1.25 V");
  od_low_on_a: assert property (
    (linear_reg_enable_pin_i && !ctl_above_0v678_i) [*6] |-> !multifunction_open_drain_oe_n_o)
    else $error("drain off in low band");
endmodule
bind blp_protect blp_protect_chk chk_i (.*);

// ---- verif/blp_stage_model.sv ----
// Power stage and pull-up stand-in for the protection logic
`timescale 1ns/1ps
module blp_stage_model (
  input  wire clk_i,
  input  wire run_i,
  input  wire od_oe_n_i,
  input  wire od_i,
  output reg  sw_cycle_o,
  output wire od_wire_o
);
  reg [1:0] ph_q = 2'h0;
  initial sw_cycle_o = 1'b0;
  // Marker rests low while stopped, so no stray switching cycle is counted
  always @(posedge clk_i) begin
    ph_q       <= run_i ? ph_q + 2'h1 : 2'h0;
    sw_cycle_o <= run_i & ph_q[1];
  end
  assign od_wire_o = od_oe_n_i ? 1'b1 : od_i;
endmodule

// ---- verif/blp_protect_tb.sv ----
// Table-driven testbench for the buck and linear protection logic
`timescale 1ns/1ps
module blp_protect_tb;
  reg     clk = 1'b0;
  reg     rstn = 1'b0;
  reg     [15:0] st = 16'h0000;
  wire    swc, hd, ld, lin, cl, dis, pok, pok_oe, od, od_oe, ovf, uvf, od_w;
  wire    [11:0] obs = {hd, ld, lin, cl, dis, pok_oe, od_oe, ovf, uvf, od_w, pok, 1'b0};
  integer n_mismatch = 0;
  integer compares = 0;
  always #4 clk = ~clk;
  blp_protect #(.MID_DWELL_CYCLES(20), .UV_ARM_CYCLES(10)) uut (.sys_clk_i(clk),
    .resetn_i(rstn), .switcher_enable_pin_i(st[15]), .linear_reg_enable_pin_i(st[14]),
    .bias_lockout_i(st[13]), .over_temp_i(st[12]), .linear_overcurrent_i(st[11]),
    .sense_over_4v_i(st[10]), .fb_over_115_i(st[9]), .fb_under_70_i(st[8]),
    .sense_below_0v3_i(st[7]), .setting_below_1v36_i(st[6]), .voltage_step_i(st[5]),
    .ctl_above_1v25_i(st[2]), .ctl_above_0v716_i(st[1]), .ctl_above_0v678_i(st[0]),
    .sw_cycle_i(swc), .fb_over_110_i(st[4]), .fb_under_low_window_i(st[3]),
    .high_drive_en_o(hd), .low_drive_en_o(ld), .linear_reg_en_o(lin),
    .linear_current_limit_o(cl), .switcher_discharge_o(dis), .power_ok_output_o(pok),
    .power_ok_output_oe_n_o(pok_oe), .multifunction_open_drain_o(od),
    .multifunction_open_drain_oe_n_o(od_oe), .overvoltage_fault_o(ovf),
    .undervoltage_fault_o(uvf));
  blp_stage_model model (.clk_i(clk), .run_i(st[15]), .od_oe_n_i(od_oe), .od_i(od),
    .sw_cycle_o(swc), .od_wire_o(od_w));
  // ==========================================================
  // Apply inputs at an edge, wait, then compare the masked outputs once settled
  task step(input [15:0] s, input integer n, input [11:0] m, input [11:0] e);
    @(posedge clk);
    st <= s;
    repeat (n) @(posedge clk);
    #1;
    compares = compares + 1;
    if ((obs & m) !== e) begin
      n_mismatch = n_mismatch + 1;
      $display("BAD %0t step %0d got %h", $time, compares, obs & m);
    end
  endtask
  task final_report;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #400000 n_mismatch = n_mismatch + 1;
    final_report;
  end
  // ==========================================================
  initial begin
    step(16'h0000, 10, 12'h020, 12'h000);
    @(posedge clk) rstn <= 1'b1;
    step(16'h0000, 8, 12'h024, 12'h000);
    // Latch-off takes 10 arming plus 32 delay switching cycles of 4 clocks each
    step(16'hc100, 144, 12'h828, 12'h800);
    step(16'hc100, 40, 12'hc88, 12'h088);
    step(16'he180, 8, 12'he88, 12'h000);
    step(16'hc000, 8, 12'ha00, 12'ha00);
    $display("test undervoltage and lockout ended");
    step(16'hc200, 6, 12'hc10, 12'h410);
    step(16'hc000, 6, 12'hc10, 12'h410);
    step(16'h4000, 8, 12'h210, 12'h200);
    step(16'hc260, 8, 12'h010, 12'h000);
    step(16'hc220, 8, 12'h010, 12'h010);
    step(16'h4000, 8, 12'h010, 12'h000);
    step(16'hc000, 8, 12'h800, 12'h800);
    $display("test overvoltage ended");
    step(16'hc400, 8, 12'h800, 12'h000);
    step(16'hc000, 8, 12'h842, 12'h840);
    step(16'hc010, 8, 12'h040, 12'h000);
    step(16'hc070, 8, 12'h040, 12'h040);
    step(16'hc008, 8, 12'h040, 12'h000);
    step(16'hd000, 8, 12'ha00, 12'h000);
    step(16'hc800, 8, 12'hb18, 12'hb00);
    $display("test temperature and limit ended");
    step(16'hc003, 10, 12'h020, 12'h000);
    step(16'hc001, 8, 12'h020, 12'h000);
    step(16'hc003, 30, 12'h004, 12'h004);
    step(16'hc001, 8, 12'h020, 12'h020);
    step(16'hc000, 8, 12'h020, 12'h000);
    step(16'hc007, 8, 12'h020, 12'h020);
    step(16'h8007, 8, 12'h260, 12'h060);
    step(16'h8003, 8, 12'h020, 12'h000);
    $display("test open drain ended");
    final_report;
  end
endmodule
